// >>> dio_map.vh
/*
  constants shared by the digital i/o control block: clock rate,
  short-circuit qualification timing and data widths.
  assumes nothing beyond a verilog-2005 preprocessor.
*/
`ifndef DIO_MAP_VH
`define DIO_MAP_VH

// ==========================================================
// clock and time base
`define DIO_CLK_HZ 20000000
`define DIO_TICK_US 1000
`define DIO_TICK_CYCLES ((`DIO_CLK_HZ / 1000000) * `DIO_TICK_US)

// ==========================================================
// short-circuit qualification, least time 0.5 s in ms
`define DIO_QUAL_MS 500
`define DIO_QUAL_TICKS ((`DIO_QUAL_MS * 1000) / `DIO_TICK_US)

// ==========================================================
// widths
`define DIO_BYTE_W 8
`define DIO_BUS_ADDR_W 8
`define DIO_SW_BITS 6

`endif

// >>> dio_ms_tick.v
/*
  millisecond enable-pulse divider.
  assumes a free-running clk_i and active-low asynchronous reset.
*/
`timescale 1ns/10ps
`include "dio_map.vh"
module dio_ms_tick #(
  parameter CYCLES = `DIO_TICK_CYCLES
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // enable pulse
  output reg tick_o
);

  reg [23:0] cnt_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 24'h000000;
      tick_o <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 24'h000000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
      tick_o <= 1'b0;
    end
  end

endmodule // dio_ms_tick

// >>> dio_fault_qual.v
/*
  qualifies one group's short-circuit condition: reported only after it
  has stood for a whole qualification time; drops as soon as it clears.
  assumes tick_i is a one-cycle enable pulse every millisecond.
*/
`timescale 1ns/10ps
`include "dio_map.vh"
module dio_fault_qual #(
  parameter QUAL_TICKS = `DIO_QUAL_TICKS
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // time base and raw condition
  input wire tick_i,
  input wire fault_i,
  // qualified result
  output reg qualified_o
);

  reg [15:0] cnt_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 16'h0000;
      qualified_o <= 1'b0;
    end else if (!fault_i) begin
      cnt_q <= 16'h0000;
      qualified_o <= 1'b0;
    end else if (tick_i && !qualified_o) begin
      // counting whole ticks makes the wait at least the least time
      if (cnt_q == QUAL_TICKS) begin
        qualified_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

endmodule // dio_fault_qual

// >>> dio_ctrl.v
/*
  control logic of a backplane digital i/o module: byte-wide bus access,
  output register with forced-zero conditions, enable gating, address
  switch decode, short-circuit qualification and indicators.
  assumes all inputs are synchronous to clk_i; the bus strobe is a
  one-cycle pulse per access.
*/
// Notes on behaviour
// R1: output-inhibit command forces every output bit to zero.
// R2: outputs held zero after power-up and while the cpu is stopped.
// R3: fault signal asserts on short or overcurrent at an output driven one; with AC_MODULE set the code holds it at zero.
// R4: faults shorter than the qualification time are ignored.
// R5: a green indicator per channel shows its current state, grouped by byte.
// R6: red indicator per group: short to ground (dc) or blown fuse (ac).
// R7: module answers only accesses matching its address rocker switch.
// R8: while enabled mode is active and enable absent, bus accesses get no answer.
// R9: while disabled through the enable input, all outputs are zero.
// R10: the cpu raises an access timeout on a missing answer.
// R11: jumper fitted: enable input gates access and outputs.
// R12: jumper open: enable input ignored, module always enabled.
// R13: fault signal stays while a qualified short persists, then drops.
// R14: written bytes latch in the output register; forcing applies after it.
`timescale 1ns/10ps
`include "dio_map.vh"
module dio_ctrl #(
  parameter SW_BITS = `DIO_SW_BITS,
  parameter AC_MODULE = 0,
  parameter TICK_CYCLES = `DIO_TICK_CYCLES,
  parameter QUAL_TICKS = `DIO_QUAL_TICKS
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // backplane bus
  input wire bus_sel_i,
  input wire bus_we_i,
  input wire [`DIO_BUS_ADDR_W-1:0] bus_addr_i,
  input wire [`DIO_BYTE_W-1:0] bus_wdata_i,
  output reg [`DIO_BYTE_W-1:0] bus_rdata_o,
  output reg bus_ack_o,
  // cpu state
  input wire output_inhibit_command_i,
  input wire cpu_stop_i,
  // address switch and enable
  input wire [SW_BITS-1:0] addr_switch_i,
  input wire enable_voltage_i,
  input wire enable_jumper_i,
  // process side
  input wire [(8 << (`DIO_BUS_ADDR_W - SW_BITS))-1:0] din_i,
  input wire [(8 << (`DIO_BUS_ADDR_W - SW_BITS))-1:0] short_i,
  input wire [(1 << (`DIO_BUS_ADDR_W - SW_BITS))-1:0] fuse_blown_i,
  output reg [(8 << (`DIO_BUS_ADDR_W - SW_BITS))-1:0] dout_o,
  // indicators and signal output
  output wire [(8 << (`DIO_BUS_ADDR_W - SW_BITS))-1:0] led_green_o,
  output reg [(1 << (`DIO_BUS_ADDR_W - SW_BITS))-1:0] led_red_o,
  output reg fault_signal_o
);

  localparam SEL_W = `DIO_BUS_ADDR_W - SW_BITS;
  localparam NBYTES = 1 << SEL_W;
  localparam NBITS = NBYTES * `DIO_BYTE_W;

  // ==========================================================
  // enable and address decode
  wire enabled;
  wire addr_hit;
  wire [SEL_W-1:0] byte_sel;
  wire access;

  assign enabled = !enable_jumper_i || enable_voltage_i; // [R11] [R12]
  assign addr_hit = (bus_addr_i[`DIO_BUS_ADDR_W-1:SEL_W] == addr_switch_i); // [R7]
  assign byte_sel = bus_addr_i[SEL_W-1:0];
  assign access = bus_sel_i && addr_hit && enabled; // [R8]

  // ==========================================================
  // power-up hold: released once the cpu has left stop
  reg por_hold_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_hold_q <= 1'b1;
    end else if (!cpu_stop_i) begin
      por_hold_q <= 1'b0;
    end
  end

  // ==========================================================
  // output register
  reg [NBITS-1:0] out_q;
  integer i;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_q <= {NBITS{1'b0}};
    end else if (access && bus_we_i) begin
      for (i = 0; i < NBYTES; i = i + 1) begin
        if (byte_sel == i[SEL_W-1:0]) begin
          out_q[i*8 +: 8] <= bus_wdata_i; // [R14]
        end
      end
    end
  end

  // ==========================================================
  // forced zero, applied after the latch
  wire force_zero;

  assign force_zero = output_inhibit_command_i || cpu_stop_i || por_hold_q || !enabled;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dout_o <= {NBITS{1'b0}}; // [R2]
    end else if (force_zero) begin
      dout_o <= {NBITS{1'b0}}; // [R1] [R2] [R9]
    end else begin
      dout_o <= out_q; // [R14]
    end
  end

  assign led_green_o = dout_o; // [R5]

  // ==========================================================
  // bus answer: no answer when disabled, so the cpu times out
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_ack_o <= 1'b0;
      bus_rdata_o <= 8'h00;
    end else begin
      bus_ack_o <= access; // [R8] [R10]
      if (access && !bus_we_i) begin
        bus_rdata_o <= din_i[byte_sel*8 +: 8];
      end
    end
  end

  // ==========================================================
  // short-circuit qualification per group (one group per byte)
  wire tick;
  wire [NBYTES-1:0] grp_raw;
  wire [NBYTES-1:0] grp_qual;

  dio_ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(tick)
  );

  genvar g;
  generate
    for (g = 0; g < NBYTES; g = g + 1) begin : grp
      // only outputs currently driven to one count
      assign grp_raw[g] = |(short_i[g*8 +: 8] & dout_o[g*8 +: 8]); // [R3]

      dio_fault_qual #(
        .QUAL_TICKS(QUAL_TICKS)
      ) u_qual (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick),
        .fault_i(grp_raw[g]),
        .qualified_o(grp_qual[g]) // [R4]
      );
    end
  endgenerate

  // ==========================================================
  // red indicators and fault signal
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      led_red_o <= {NBYTES{1'b0}};
      fault_signal_o <= 1'b0;
    end else if (AC_MODULE != 0) begin
      led_red_o <= fuse_blown_i; // [R6]
      fault_signal_o <= 1'b0;
    end else begin
      led_red_o <= grp_qual; // [R6]
      fault_signal_o <= |grp_qual; // [R3] [R13]
    end
  end

endmodule // dio_ctrl

// >>> dio_ctrl_checker.sv
/* checker of dio_ctrl: bus answer, forced zero, green indicator, short filter.
   assumes the default 32-bit geometry; the fault-raise check applies to dc modules only. */
`timescale 1ns/10ps
module dio_ctrl_checker #(
  parameter TICK_CYCLES = 4,
  parameter QUAL_TICKS = 3,
  parameter AC_MODULE = 0
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // bus and control
  input wire bus_sel_i,
  input wire [7:0] bus_addr_i,
  input wire bus_ack_o,
  input wire output_inhibit_command_i,
  input wire [5:0] addr_switch_i,
  input wire enable_voltage_i,
  input wire enable_jumper_i,
  // process side
  input wire [31:0] short_i,
  input wire [31:0] dout_o,
  input wire [31:0] led_green_o,
  input wire fault_signal_o
);
  wire raw = |(short_i & dout_o);
  wire take = bus_sel_i && bus_addr_i[7:2] == addr_switch_i;
  wire off = enable_jumper_i && !enable_voltage_i;
  reg [7:0] run_q;
  // ==========================================
  // cycles the raw short has stood
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) run_q <= 8'h00;
    else if (!raw) run_q <= 8'h00;
    else if (run_q != 8'hff) run_q <= run_q + 8'h01;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence raw_gone;
    !raw [*3];
  endsequence
  a_inhibit_zero: assert property (output_inhibit_command_i |=> dout_o == 32'h0)
    else $error("outputs live under inhibit");
  a_disabled_zero: assert property (off |=> dout_o == 32'h0)
    else $error("outputs live while disabled");
  a_match_ack: assert property (take && !off |=> bus_ack_o)
    else $error("no answer");
  a_mismatch_noack: assert property (bus_sel_i && !take |=> !bus_ack_o)
    else $error("answer to foreign address");
  a_disabled_noack: assert property (bus_sel_i && off |=> !bus_ack_o)
    else $error("answer while disabled");
  a_green_follows: assert property (led_green_o == dout_o)
    else $error("green differs");
  a_fault_clears: assert property (raw_gone |-> !fault_signal_o)
    else $error("fault stuck");
  a_short_filter: assert property (
      $rose(fault_signal_o) |-> $past(run_q, 2) >= QUAL_TICKS * TICK_CYCLES)
    else $error("short reported early");
  a_fault_raise: assert property (
      AC_MODULE == 0 && run_q >= (QUAL_TICKS + 1) * TICK_CYCLES + 1 |-> fault_signal_o)
    else $error("short not reported");
endmodule // dio_ctrl_checker

bind dio_ctrl dio_ctrl_checker #(
  .TICK_CYCLES(TICK_CYCLES),
  .QUAL_TICKS(QUAL_TICKS),
  .AC_MODULE(AC_MODULE)
) u_chk (
  .clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .bus_sel_i(bus_sel_i),
  .bus_addr_i(bus_addr_i),
  .bus_ack_o(bus_ack_o),
  .output_inhibit_command_i(output_inhibit_command_i),
  .addr_switch_i(addr_switch_i),
  .enable_voltage_i(enable_voltage_i),
  .enable_jumper_i(enable_jumper_i),
  .short_i(short_i),
  .dout_o(dout_o),
  .led_green_o(led_green_o),
  .fault_signal_o(fault_signal_o)
);

// >>> dio_cpu_model.sv
/* cpu side of the backplane bus: one-cycle strobe, bounded answer wait.
   assumes the answer is sampled on rising clk_i. */
`timescale 1ns/10ps
module dio_cpu_model (
  // clock and answer
  input wire clk_i,
  input wire ack_i,
  input wire [7:0] rdata_i,
  // request
  output logic sel_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00
);
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q, output logic to);
    int n;
    to = 1'b1;
    q = 8'h00;
    @(posedge clk_i);
    sel_o <= 1'b1;
    we_o <= w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    sel_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    for (n = 0; n < 8 && to; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        to = 1'b0;
        q = rdata_i;
      end
    end
  endtask
endmodule // dio_cpu_model

// >>> digital_io_module_control_tb.sv
/* testbench of dio_ctrl: cpu model on the bus, bench on the process side.
   assumes the checker binds itself. */
`timescale 1ns/10ps
module digital_io_module_control_tb;
  logic clk_i = 1'b0, arst_n_i = 1'b0, inh = 1'b0, stop = 1'b1, volt = 1'b1, jmp = 1'b1;
  logic sel, we, to, ack, fault;
  logic [5:0] sw = 6'h00;
  logic [31:0] din = 32'h0, sht = 32'h0, mem = 32'h0, dout, green;
  logic [7:0] addr, wd, rd, q;
  logic [3:0] red, red_ac;
  logic [3:0] fuse = 4'h0;
  logic fault_ac;
  logic [8:0] exp_q[$];
  logic [8:0] note;
  int fail_count = 0, compares = 0, i;
  always #25 clk_i = ~clk_i;
  dio_cpu_model cpu (.clk_i(clk_i), .ack_i(ack), .rdata_i(rd), .sel_o(sel), .we_o(we),
    .addr_o(addr), .wdata_o(wd));
  dio_ctrl #(.TICK_CYCLES(4), .QUAL_TICKS(3)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .bus_sel_i(sel), .bus_we_i(we), .bus_addr_i(addr), .bus_wdata_i(wd), .bus_rdata_o(rd),
    .bus_ack_o(ack), .output_inhibit_command_i(inh), .cpu_stop_i(stop), .addr_switch_i(sw),
    .enable_voltage_i(volt), .enable_jumper_i(jmp), .din_i(din), .short_i(sht),
    .fuse_blown_i(fuse), .dout_o(dout), .led_green_o(green), .led_red_o(red),
    .fault_signal_o(fault));
  dio_ctrl #(.AC_MODULE(1), .TICK_CYCLES(4), .QUAL_TICKS(3)) dut_ac (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .bus_sel_i(sel), .bus_we_i(we), .bus_addr_i(addr), .bus_wdata_i(wd),
    .bus_rdata_o(), .bus_ack_o(), .output_inhibit_command_i(inh), .cpu_stop_i(stop),
    .addr_switch_i(sw), .enable_voltage_i(volt), .enable_jumper_i(jmp), .din_i(din),
    .short_i(sht), .fuse_blown_i(fuse), .dout_o(), .led_green_o(), .led_red_o(red_ac),
    .fault_signal_o(fault_ac));
  task automatic chk(input string n, input logic [31:0] e, s);
    compares++;
    if (e !== s) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d, input logic ok);
    if (ok) exp_q.push_back({!w, din[8*a[1:0]+:8]});
    if (ok && w) mem[8*a[1:0]+:8] = d;
    cpu.access(w, a, d, q, to);
    chk("timeout", {31'h0, !ok}, {31'h0, to});
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // answer monitor
  always @(posedge clk_i) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) chk("ack", 32'h0, 32'h1);
      else begin
        note = exp_q.pop_front();
        if (note[8]) chk("rdata", {24'h0, note[7:0]}, {24'h0, rd});
      end
    end
  end
  initial begin
    tk(3000);
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'h3f68));
    tk(16);
    arst_n_i <= 1'b1;
    sw <= $urandom;
    din <= $urandom;
    tk(1);
    acc(1, {sw, 2'd0}, 8'ha5, 1);
    tk(2);
    chk("dout", 32'h0, dout);
    stop <= 1'b0;
    tk(3);
    chk("dout", mem, dout);
    for (i = 0; i < 4; i++) begin
      acc(1, {sw, i[1:0]}, $urandom, 1);
      acc(0, {sw, i[1:0]}, 8'h00, 1);
    end
    acc(1, {sw, 2'd1}, 8'hff, 1);
    tk(2);
    chk("dout", mem, dout);
    chk("green", mem, green);
    inh <= 1'b1;
    tk(2);
    chk("dout", 32'h0, dout);
    inh <= 1'b0;
    tk(3);
    chk("dout", mem, dout);
    acc(1, {sw ^ 6'h01, 2'd1}, 8'h3c, 0);
    acc(0, {sw ^ 6'h20, 2'd0}, 8'h00, 0);
    volt <= 1'b0;
    tk(2);
    chk("dout", 32'h0, dout);
    acc(1, {sw, 2'd2}, 8'h77, 0);
    jmp <= 1'b0;
    tk(3);
    chk("dout", mem, dout);
    acc(0, {sw, 2'd3}, 8'h00, 1);
    volt <= 1'b1;
    jmp <= 1'b1;
    sht <= 32'h100;
    tk(5);
    sht <= 32'h0;
    tk(20);
    chk("fault", 32'h0, {31'h0, fault});
    sht <= 32'h100;
    tk(40);
    chk("fault", 32'h1, {31'h0, fault});
    chk("red", 32'h2, {28'h0, red});
    chk("fault_ac", 32'h0, {31'h0, fault_ac});
    sht <= 32'h0;
    tk(4);
    chk("fault", 32'h0, {31'h0, fault});
    chk("red", 32'h0, {28'h0, red});
    fuse <= $urandom | 32'h1;
    tk(2);
    chk("red_ac", {28'h0, fuse}, {28'h0, red_ac});
    chk("notes", 32'h0, exp_q.size());
    final_report();
  end
endmodule // digital_io_module_control_tb
